//--- rtl/lstx_link_regs.sv
// One link slice: violation flags, excess-zero count, reference clock control,
// interrupt summaries and the transmit system interface receiver.
// Assumes line events and interrupt flags come from core clock logic; pins are asynchronous.
//
// The strobed register port is this design's own decision.
`timescale 1ns/10ps

// Operation
// (R1) Bipolar or code violation sets a flag; writing one clears it.
// (R2) Excess-zero counter wrap sets a flag; writing one clears it.
// (R3) Excess-zero count reads as high byte at 0x03C, low at 0x03D, reset zero.
// (R4) During loss of signal, reference outputs give master clock or steady high.
// (R5) Line summary is set while any line-side sub-function has an interrupt.
// (R6) Summary bits at 0x040 follow six framer function interrupts.
// (R7) Summary bits at 0x041 follow link controllers, elastic store, system interface.
// (R8) Data and signaling are sampled on the edge chosen by the data edge bit.
// (R9) Frame pulse is updated or sampled on the edge chosen by the pulse edge bit.
// (R10) Software programs the edge, rate, polarity and type bits alike in all links.
// (R11) Rate bit selects a clock at data rate or at twice the data rate; in master mode the code ignores it and generates a data-rate clock.
// (R12) Software sets the rate bit alike when all links share link one timing.
// (R13) Polarity bit chooses an active high or active low frame pulse.
// (R14) Type bit zero: pulse marks first bit of each basic frame.
// (R15) Type bit one: pulse marks first bit of the generated multiframe.
// (R16) Sub-mode bit: device drives clock and pulse, or system side drives them.
// (R17) Frame start lags the pulse by a slot offset, 0 to 31 or 0 to 127.
// (R18) Signaling bits stay aligned slot by slot with data whatever the offset.
// (R19) Four links repeat this map at a spacing of 0x100.
// (R20) A 3-bit bit offset also applies; an edge bit picks the double-rate edge.
// (R21) Each summary bit is a live OR of its source flags; reads change nothing.
// (R22) Reading the high count byte latches the low byte for a coherent pair.
module lstx_link_regs
  import lstx_pkg::*;
#(
  parameter logic [1:0] LINK_INDEX = 2'h0
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic bipolar_violation,
  input wire logic excess_zero,
  input wire logic loss_of_signal,
  input wire logic master_clock,
  input wire logic [7:0] line_irq_flags,
  input wire logic [5:0][7:0] func0_irq_flags,
  input wire logic [7:0][7:0] func1_irq_flags,
  input wire logic mux_mode,
  input wire logic crc_mf_on,
  input wire logic sig_mf_on,
  input wire logic tx_sys_clock_in,
  output logic tx_sys_clock_out,
  output logic tx_sys_clock_oe_n,
  input wire logic tx_sys_frame_pulse_in,
  output logic tx_sys_frame_pulse_out,
  output logic tx_sys_frame_pulse_oe_n,
  input wire logic tx_sys_data,
  input wire logic tx_sys_signaling,
  output logic ref_output_a,
  output logic ref_output_b,
  output logic tx_slot_valid,
  output logic [6:0] tx_slot_num,
  output logic [7:0] tx_slot_data,
  output logic [7:0] tx_slot_sig
);
  import lstx_pkg::*;

  // ****************************************
  // Register state
  // ****************************************
  logic code_violation_flag;
  logic counter_wrap_flag;
  logic ref_out_high_on_loss;
  logic line_side_irq_sum;
  logic [5:0] func_sum0;
  logic [7:0] func_sum1;
  logic [4:0] tx_opt;
  logic tx_timing_sub_sel;
  logic [6:0] tx_slot_shift;
  logic [3:0] tx_bit_reg;
  logic [7:0] next_rdata;

  logic data_edge_sel;
  logic pulse_edge_sel;
  logic clock_rate_double;
  logic pulse_polarity_sel;
  logic pulse_kind_sel;
  logic [2:0] tx_bit_shift;
  logic second_edge_sel;

  assign data_edge_sel = tx_opt[DE_BIT];
  assign pulse_edge_sel = tx_opt[FE_BIT];
  assign clock_rate_double = tx_opt[CMS_BIT];
  assign pulse_polarity_sel = tx_opt[PULSE_POLARITY_SEL_BIT];
  assign pulse_kind_sel = tx_opt[PULSE_KIND_SEL_BIT];
  assign tx_bit_shift = tx_bit_reg[2:0];
  assign second_edge_sel = tx_bit_reg[EDGE_BIT];

  // Matches this link's copy of a register; link n sits n pages above link 0.
  function automatic logic hit(input logic [9:0] addr, input logic [7:0] off);
    hit = (addr[9:8] == LINK_INDEX) && (addr[7:0] == off); // [R19]
  endfunction

  logic wr_flags;
  assign wr_flags = reg_wr && hit(reg_addr, OFF_IRQ_STATUS);

  // ****************************************
  // Excess-zero counter
  // ****************************************
  lstx_cnt_if cnt_bus();

  assign cnt_bus.inc = excess_zero;
  assign cnt_bus.rd_high = reg_rd && hit(reg_addr, OFF_CNT_HIGH); // [R22]

  lstx_exz_counter u_counter (
    .core_clk(core_clk),
    .rst(rst),
    .cnt(cnt_bus)
  );

  // ****************************************
  // Sticky flags
  // ****************************************
  // A new event in the same cycle as the clearing write keeps the flag set.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      code_violation_flag <= 1'b0;
    end else if (bipolar_violation) begin
      code_violation_flag <= 1'b1; // [R1]
    end else if (wr_flags && reg_wdata[CV_BIT]) begin
      code_violation_flag <= 1'b0; // [R1]
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      counter_wrap_flag <= 1'b0;
    end else if (cnt_bus.wrap) begin
      counter_wrap_flag <= 1'b1; // [R2]
    end else if (wr_flags && reg_wdata[WRAP_BIT]) begin
      counter_wrap_flag <= 1'b0; // [R2]
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ref_out_high_on_loss <= REF_CTRL_RESET;
      tx_opt <= TX_OPT_RESET;
      tx_timing_sub_sel <= TX_MODE_RESET;
      tx_slot_shift <= TX_SLOT_RESET;
      tx_bit_reg <= TX_BIT_RESET;
    end else if (reg_wr) begin
      if (hit(reg_addr, OFF_REF_CTRL)) begin
        ref_out_high_on_loss <= reg_wdata[0];
      end
      if (hit(reg_addr, OFF_TX_OPT)) begin
        tx_opt <= reg_wdata[4:0];
      end
      if (hit(reg_addr, OFF_TX_MODE)) begin
        tx_timing_sub_sel <= reg_wdata[0];
      end
      if (hit(reg_addr, OFF_TX_SLOT)) begin
        tx_slot_shift <= reg_wdata[6:0];
      end
      if (hit(reg_addr, OFF_TX_BIT)) begin
        tx_bit_reg <= reg_wdata[3:0];
      end
    end
  end

  // ****************************************
  // Interrupt summaries
  // ****************************************
  // Summaries are recomputed every cycle, so a read never disturbs them.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      line_side_irq_sum <= 1'b0;
      func_sum0 <= 6'h00;
      func_sum1 <= 8'h00;
    end else begin
      line_side_irq_sum <= |line_irq_flags; // [R5] [R21]
      for (int i = 0; i < 6; i++) begin
        func_sum0[i] <= |func0_irq_flags[i]; // [R6] [R21]
      end
      for (int i = 0; i < 8; i++) begin
        func_sum1[i] <= |func1_irq_flags[i]; // [R7] [R21]
      end
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  always_comb begin
    next_rdata = 8'h00;
    if (hit(reg_addr, OFF_IRQ_STATUS)) begin
      next_rdata = {6'h00, code_violation_flag, counter_wrap_flag};
    end else if (hit(reg_addr, OFF_CNT_HIGH)) begin
      next_rdata = cnt_bus.count[15:8]; // [R3]
    end else if (hit(reg_addr, OFF_CNT_LOW)) begin
      next_rdata = cnt_bus.low_snap; // [R3] [R22]
    end else if (hit(reg_addr, OFF_REF_CTRL)) begin
      next_rdata = {7'h00, ref_out_high_on_loss};
    end else if (hit(reg_addr, OFF_LINE_SUM)) begin
      next_rdata = {7'h00, line_side_irq_sum};
    end else if (hit(reg_addr, OFF_FUNC_SUM0)) begin
      next_rdata = {2'h0, func_sum0};
    end else if (hit(reg_addr, OFF_FUNC_SUM1)) begin
      next_rdata = func_sum1;
    end else if (hit(reg_addr, OFF_TX_OPT)) begin
      next_rdata = {3'h0, tx_opt};
    end else if (hit(reg_addr, OFF_TX_MODE)) begin
      next_rdata = {7'h00, tx_timing_sub_sel};
    end else if (hit(reg_addr, OFF_TX_SLOT)) begin
      next_rdata = {1'b0, tx_slot_shift};
    end else if (hit(reg_addr, OFF_TX_BIT)) begin
      next_rdata = {4'h0, tx_bit_reg};
    end
  end

  // Read data stand for exactly one cycle and are zero otherwise.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ****************************************
  // Pin synchronisers and reference clocks
  // ****************************************
  logic [PIN_COUNT-1:0] pins_sync;
  logic [PIN_COUNT-1:0] pins_prev;

  lstx_pin_sync u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .pins_in({tx_sys_frame_pulse_in, tx_sys_signaling, tx_sys_data, tx_sys_clock_in,
              master_clock}),
    .pins_sync(pins_sync),
    .pins_prev(pins_prev)
  );

  // The master clock is rebuilt from core clock samples, so jitter is one core period.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ref_output_a <= 1'b0;
      ref_output_b <= 1'b0;
    end else if (loss_of_signal && ref_out_high_on_loss) begin
      ref_output_a <= 1'b1; // [R4]
      ref_output_b <= 1'b1; // [R4]
    end else begin
      ref_output_a <= pins_sync[PIN_MCLK]; // [R4]
      ref_output_b <= pins_sync[PIN_MCLK]; // [R4]
    end
  end

  // ****************************************
  // Transmit timing mode and clock
  // ****************************************
  lstx_mode_t mode;
  logic [4:0] div_cnt;
  logic gen_toggle;
  logic ck_rise;
  logic ck_fall;

  always_comb begin
    if (mux_mode) begin
      mode = TM_MUX;
    end else if (tx_timing_sub_sel) begin
      mode = TM_SLAVE; // [R16]
    end else begin
      mode = TM_MASTER; // [R16]
    end
  end

  assign gen_toggle = (div_cnt == 5'(TX_HALF_CYCLES - 1));

  always_ff @(posedge core_clk) begin
    if (rst) begin
      div_cnt <= 5'h00;
      tx_sys_clock_out <= 1'b0;
    end else if (gen_toggle) begin
      div_cnt <= 5'h00;
      tx_sys_clock_out <= ~tx_sys_clock_out;
    end else begin
      div_cnt <= 5'(div_cnt + 5'h01);
    end
  end

  always_comb begin
    case (mode)
      TM_MASTER: begin
        ck_rise = gen_toggle && !tx_sys_clock_out;
        ck_fall = gen_toggle && tx_sys_clock_out;
      end
      default: begin
        ck_rise = pins_sync[PIN_TCK] && !pins_prev[PIN_TCK];
        ck_fall = !pins_sync[PIN_TCK] && pins_prev[PIN_TCK];
      end
    endcase
  end

  // ****************************************
  // Frame position and pulse
  // ****************************************
  logic data_tick_raw;
  logic fp_tick;
  logic is_double;
  logic phase;
  logic bit_tick;
  logic fp_level;
  logic fp_last;
  logic fp_held;
  logic frame_hit;
  logic [9:0] last_bit;
  logic [9:0] pos;
  logic [9:0] cur;
  logic [3:0] mf_cnt;
  logic [6:0] slot_eff;
  logic [9:0] shift_bits;
  logic [9:0] data_idx;
  logic fp_active;

  assign data_tick_raw = data_edge_sel ? ck_rise : ck_fall; // [R8]
  assign fp_tick = pulse_edge_sel ? ck_rise : ck_fall; // [R9]
  assign is_double = clock_rate_double && (mode != TM_MASTER); // [R11]
  assign bit_tick = data_tick_raw && (!is_double || (phase == second_edge_sel)); // [R20]
  assign fp_level = pins_sync[PIN_TFP] ^ pulse_polarity_sel; // [R13]
  assign frame_hit = (mode != TM_MASTER) &&
                     (fp_held || (fp_tick && fp_level && !fp_last));
  assign last_bit = (mode == TM_MUX) ? LAST_BIT_MUX : LAST_BIT_SINGLE;
  assign cur = frame_hit ? 10'h000 : pos;
  assign slot_eff = (mode == TM_MUX) ? tx_slot_shift : (tx_slot_shift & SLOT_MASK_SINGLE);
  assign shift_bits = {slot_eff, tx_bit_shift}; // [R17] [R20]
  assign data_idx = 10'(cur - shift_bits) & last_bit; // [R17]
  assign fp_active = (pos == 10'h000) &&
                     (!pulse_kind_sel || !(crc_mf_on || sig_mf_on) || mf_cnt == 4'h0);

  // An incoming pulse is remembered until the next data edge, since the two
  // edges may differ; a rising level also covers the level-change pulse form.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fp_last <= 1'b0;
      fp_held <= 1'b0;
    end else begin
      if (fp_tick) begin
        fp_last <= fp_level; // [R9]
      end
      if (bit_tick) begin
        fp_held <= 1'b0;
      end else if (fp_tick && fp_level && !fp_last && mode != TM_MASTER) begin
        fp_held <= 1'b1; // [R14] [R15]
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      phase <= 1'b0;
    end else if (frame_hit && bit_tick) begin
      phase <= 1'b0;
    end else if (data_tick_raw && is_double) begin
      phase <= ~phase; // [R20]
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pos <= 10'h000;
      mf_cnt <= 4'h0;
    end else if (bit_tick) begin
      if (cur == last_bit) begin
        pos <= 10'h000;
        mf_cnt <= 4'(mf_cnt + 4'h1);
      end else begin
        pos <= 10'(cur + 10'h001);
      end
      if (frame_hit) begin
        mf_cnt <= 4'h0;
      end
    end
  end

  // The pulse pin is driven only while the device owns the timing.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_sys_frame_pulse_out <= 1'b0;
      tx_sys_clock_oe_n <= 1'b1;
      tx_sys_frame_pulse_oe_n <= 1'b1;
    end else begin
      tx_sys_clock_oe_n <= (mode != TM_MASTER); // [R16]
      tx_sys_frame_pulse_oe_n <= (mode != TM_MASTER); // [R16]
      if (fp_tick) begin
        tx_sys_frame_pulse_out <= fp_active ^ pulse_polarity_sel; // [R13] [R14] [R15]
      end
    end
  end

  // ****************************************
  // Slot assembly
  // ****************************************
  logic [6:0] data_shift;
  logic [6:0] sig_shift;

  // Data and signaling share one index, so they leave together per slot.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      data_shift <= 7'h00;
      sig_shift <= 7'h00;
      tx_slot_valid <= 1'b0;
      tx_slot_num <= 7'h00;
      tx_slot_data <= 8'h00;
      tx_slot_sig <= 8'h00;
    end else begin
      tx_slot_valid <= 1'b0;
      if (bit_tick) begin
        data_shift <= {data_shift[5:0], pins_sync[PIN_TD]}; // [R8]
        sig_shift <= {sig_shift[5:0], pins_sync[PIN_TSIG]}; // [R8]
        if (data_idx[2:0] == 3'h7) begin
          tx_slot_valid <= 1'b1;
          tx_slot_num <= data_idx[9:3]; // [R17]
          tx_slot_data <= {data_shift, pins_sync[PIN_TD]};
          tx_slot_sig <= {sig_shift, pins_sync[PIN_TSIG]}; // [R18]
        end
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  cv_flag_set_a: assert property (bipolar_violation |=> code_violation_flag) // [R1]
    else $error("code violation flag not set");
  wrap_flag_set_a: assert property ( // [R2]
      excess_zero && cnt_bus.count == 16'hFFFF
      |=> counter_wrap_flag && cnt_bus.count == 16'h0000)
    else $error("counter wrap flag not set");
  count_high_read_a: assert property ( // [R3]
      reg_rd && hit(reg_addr, OFF_CNT_HIGH) |=> reg_rdata == $past(cnt_bus.count[15:8]))
    else $error("high count byte read wrong");
  pair_read_a: assert property ( // [R22]
      reg_rd && hit(reg_addr, OFF_CNT_HIGH) ##1 (reg_rd && hit(reg_addr, OFF_CNT_LOW))
      |=> reg_rdata == $past(cnt_bus.count[7:0], 2))
    else $error("low byte not latched by high read");
  ref_high_a: assert property ( // [R4]
      loss_of_signal && ref_out_high_on_loss |=> ref_output_a && ref_output_b)
    else $error("reference outputs not held high");
  line_sum_a: assert property (##1 line_side_irq_sum == $past(|line_irq_flags)) // [R5]
    else $error("line summary wrong");
  func_sum_a: assert property ( // [R6]
      reg_rd && hit(reg_addr, OFF_FUNC_SUM0) && $stable(func0_irq_flags)
      |=> reg_rdata[5:0] == func_sum0)
    else $error("function summary read wrong");
  slot_range_a: assert property (tx_slot_valid && mode != TM_MUX |-> tx_slot_num < 7'h20) // [R17]
    else $error("slot number beyond single frame");
  // Three cycles, since the enables are registered and still show reset one edge after it.
  master_drive_a: assert property ( // [R16]
      (mode == TM_MASTER) [*3] |-> !tx_sys_clock_oe_n && !tx_sys_frame_pulse_oe_n)
    else $error("timing pins not driven in master mode");
endmodule

//--- inc/lstx_pkg.sv
// Constants and types shared by the link status and transmit system interface slice.
// Assumes a single 100 MHz core clock; every other clock is sampled as a plain input.
package lstx_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int TX_BIT_PERIOD_NS = 488;
  localparam int TX_HALF_CYCLES = TX_BIT_PERIOD_NS / (2 * CLK_PERIOD_NS);

  // ****************************************
  // Register offsets within one link
  // ****************************************
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h3B;
  localparam logic [7:0] OFF_CNT_HIGH = 8'h3C;
  localparam logic [7:0] OFF_CNT_LOW = 8'h3D;
  localparam logic [7:0] OFF_REF_CTRL = 8'h3E;
  localparam logic [7:0] OFF_LINE_SUM = 8'h3F;
  localparam logic [7:0] OFF_FUNC_SUM0 = 8'h40;
  localparam logic [7:0] OFF_FUNC_SUM1 = 8'h41;
  localparam logic [7:0] OFF_TX_OPT = 8'h42;
  localparam logic [7:0] OFF_TX_MODE = 8'h43;
  localparam logic [7:0] OFF_TX_SLOT = 8'h44;
  localparam logic [7:0] OFF_TX_BIT = 8'h45;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int CV_BIT = 1;
  localparam int WRAP_BIT = 0;
  localparam int DE_BIT = 4;
  localparam int FE_BIT = 3;
  localparam int CMS_BIT = 2;
  localparam int PULSE_POLARITY_SEL_BIT = 1;
  localparam int PULSE_KIND_SEL_BIT = 0;
  localparam int EDGE_BIT = 3;
  localparam logic [4:0] TX_OPT_RESET = 5'h00;
  localparam logic TX_MODE_RESET = 1'b0;
  localparam logic [6:0] TX_SLOT_RESET = 7'h00;
  localparam logic [3:0] TX_BIT_RESET = 4'h0;
  localparam logic REF_CTRL_RESET = 1'b0;

  // ****************************************
  // Frame geometry and pins
  // ****************************************
  localparam logic [9:0] LAST_BIT_SINGLE = 10'h0FF;
  localparam logic [9:0] LAST_BIT_MUX = 10'h3FF;
  localparam logic [6:0] SLOT_MASK_SINGLE = 7'h1F;
  localparam int PIN_COUNT = 5;
  localparam int PIN_MCLK = 0;
  localparam int PIN_TCK = 1;
  localparam int PIN_TD = 2;
  localparam int PIN_TSIG = 3;
  localparam int PIN_TFP = 4;

  typedef enum {TM_MASTER, TM_SLAVE, TM_MUX} lstx_mode_t;

endpackage

//--- inc/lstx_cnt_if.sv
// Carries the excess-zero event, the high byte read and the count between top and counter.
// Assumes both ends run on the core clock.
`timescale 1ns/10ps
interface lstx_cnt_if;
  logic inc;
  logic rd_high;
  logic [15:0] count;
  logic [7:0] low_snap;
  logic wrap;
  modport owner(input inc, input rd_high, output count, output low_snap, output wrap);
  modport user(output inc, output rd_high, input count, input low_snap, input wrap);
endinterface

//--- rtl/lstx_pin_sync.sv
// Two-stage synchroniser for the pins that arrive from outside the core clock domain.
// Also keeps the previous synchronised level so the caller can find edges.
`timescale 1ns/10ps
module lstx_pin_sync
  import lstx_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [lstx_pkg::PIN_COUNT-1:0] pins_in,
  output logic [lstx_pkg::PIN_COUNT-1:0] pins_sync,
  output logic [lstx_pkg::PIN_COUNT-1:0] pins_prev
);
  logic [PIN_COUNT-1:0] stage1;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      stage1 <= '0;
      pins_sync <= '0;
      pins_prev <= '0;
    end else begin
      stage1 <= pins_in;
      pins_sync <= stage1;
      pins_prev <= pins_sync;
    end
  end
endmodule

//--- rtl/lstx_exz_counter.sv
// Sixteen-bit excess-zero error counter with a low byte snapshot taken on a high byte read.
// Assumes the increment and read strobes are single core clock pulses.
`timescale 1ns/10ps
module lstx_exz_counter
  import lstx_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  lstx_cnt_if.owner cnt
);
  // The counter rolls over rather than saturating, so the wrap flag is the only trace.
  assign cnt.wrap = cnt.inc && (cnt.count == 16'hFFFF);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt.count <= 16'h0000;
    end else if (cnt.inc) begin
      cnt.count <= 16'(cnt.count + 16'h0001);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt.low_snap <= 8'h00;
    end else if (cnt.rd_high) begin
      cnt.low_snap <= cnt.count[7:0];
    end
  end
endmodule

//--- bench/lstx_sys_model.sv
// Backplane model: drives one frame of two slots on the transmit system pins.
// Assumes the link is in clock slave mode with rising edges selected.
`timescale 1ns/10ps
module lstx_sys_model (
  input wire logic go,
  input wire logic [7:0] data_byte,
  input wire logic [7:0] sig_byte,
  output logic sck,
  output logic fp,
  output logic sd,
  output logic sg
);
  initial begin
    sck = 1'b0;
    fp = 1'b0;
    sd = 1'b0;
    sg = 1'b0;
  end
  // The clock runs only within the frame, one period per bit.
  always @(posedge go) begin
    for (int i = 0; i < 16; i++) begin
      fp = (i == 0);
      sd = data_byte[7 - i % 8];
      sg = sig_byte[7 - i % 8];
      #80 sck = 1'b1;
      #80 sck = 1'b0;
    end
    // Released data and signaling lines show the inverse so a late sample cannot pass by luck.
    fp = 1'b0;
    sd = ~sd;
    sg = ~sg;
  end
endmodule

//--- bench/test_lstx_link_regs.sv
// Self-checking bench for one link slice at page zero.
// Assumes a 100 MHz core clock and the backplane model above.
`timescale 1ns/10ps
module test_lstx_link_regs;
  import lstx_pkg::*;
  logic core_clk, rst, reg_wr, reg_rd, bipolar_violation, excess_zero, loss_of_signal;
  logic master_clock, go, sck, fp, sd, sg, ck_oe_n, ref_a, ref_b, s_valid;
  logic ck_out, fp_out, fp_oe_n;
  logic [9:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, line_irq_flags, s_data, s_sig;
  logic [5:0][7:0] func0_irq_flags;
  logic [7:0][7:0] func1_irq_flags;
  logic [6:0] s_num;
  int fail_count = 0;
  int num_checks = 0;

  lstx_link_regs u_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bipolar_violation(bipolar_violation), .excess_zero(excess_zero),
    .loss_of_signal(loss_of_signal), .master_clock(master_clock),
    .line_irq_flags(line_irq_flags), .func0_irq_flags(func0_irq_flags),
    .func1_irq_flags(func1_irq_flags), .mux_mode(1'b0), .crc_mf_on(1'b0),
    .sig_mf_on(1'b0), .tx_sys_clock_in(sck), .tx_sys_clock_out(ck_out),
    .tx_sys_clock_oe_n(ck_oe_n), .tx_sys_frame_pulse_in(fp), .tx_sys_frame_pulse_out(fp_out),
    .tx_sys_frame_pulse_oe_n(fp_oe_n), .tx_sys_data(sd), .tx_sys_signaling(sg),
    .ref_output_a(ref_a), .ref_output_b(ref_b), .tx_slot_valid(s_valid),
    .tx_slot_num(s_num), .tx_slot_data(s_data), .tx_slot_sig(s_sig));
  lstx_sys_model u_sys (.go(go), .data_byte(8'hA5), .sig_byte(8'h3C), .sck(sck),
    .fp(fp), .sd(sd), .sg(sg));

  // ****
  // Bus and compare tasks
  // ****
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  task automatic wait_slot();
    repeat (2000) begin
      @(posedge core_clk);
      #1;
      if (s_valid === 1'b1) break;
    end
    chk({7'h00, s_valid}, 8'h01);
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    chk({7'h00, ck_oe_n}, 8'h00);
    rd_chk(10'h03C, 8'h00);
    rd_chk(10'h03D, 8'h00);
    rd_chk(10'h042, 8'h00);
    rd_chk(10'h050, 8'h00);
    wr(10'h144, 8'h1F);
    rd_chk(10'h044, 8'h00);
  endtask
  task automatic t_flags();
    @(posedge core_clk) bipolar_violation <= 1'b1;
    @(posedge core_clk) bipolar_violation <= 1'b0;
    rd_chk(10'h03B, 8'h02);
    wr(10'h03B, 8'h02);
    rd_chk(10'h03B, 8'h00);
  endtask
  task automatic t_count();
    @(posedge core_clk) excess_zero <= 1'b1;
    repeat (3) @(posedge core_clk);
    excess_zero <= 1'b0;
    // High and low reads back to back, with no idle cycle between the strobes.
    @(posedge core_clk) {reg_rd, reg_addr} <= {1'b1, 10'h03C};
    @(posedge core_clk) reg_addr <= 10'h03D;
    #1 chk(reg_rdata, 8'h00);
    @(posedge core_clk) reg_rd <= 1'b0;
    #1 chk(reg_rdata, 8'h03);
    rd_chk(10'h03C, 8'h00);
    @(posedge core_clk) excess_zero <= 1'b1;
    @(posedge core_clk) excess_zero <= 1'b0;
    rd_chk(10'h03D, 8'h03);
    // Four counted so far; this run takes the count through 0xFFFF.
    @(posedge core_clk) excess_zero <= 1'b1;
    repeat (65532) @(posedge core_clk);
    excess_zero <= 1'b0;
    rd_chk(10'h03B, 8'h01);
    rd_chk(10'h03C, 8'h00);
    rd_chk(10'h03D, 8'h00);
  endtask
  task automatic t_ref();
    @(posedge core_clk);
    master_clock <= 1'b1;
    loss_of_signal <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk({6'h00, ref_a, ref_b}, 8'h03);
    master_clock <= 1'b0;
    repeat (6) @(posedge core_clk);
    chk({6'h00, ref_a, ref_b}, 8'h00);
    wr(10'h03E, 8'h01);
    repeat (3) @(posedge core_clk);
    chk({6'h00, ref_a, ref_b}, 8'h03);
    loss_of_signal <= 1'b0;
  endtask
  task automatic t_sum();
    @(posedge core_clk);
    line_irq_flags <= 8'h10;
    func0_irq_flags[5] <= 8'h04;
    func1_irq_flags[7] <= 8'h80;
    func1_irq_flags[0] <= 8'h01;
    repeat (3) @(posedge core_clk);
    rd_chk(10'h03F, 8'h01);
    rd_chk(10'h040, 8'h20);
    rd_chk(10'h041, 8'h81);
    rd_chk(10'h041, 8'h81);
    @(posedge core_clk);
    func0_irq_flags[5] <= 8'h00;
    line_irq_flags <= 8'h00;
    repeat (3) @(posedge core_clk);
    rd_chk(10'h040, 8'h00);
    rd_chk(10'h03F, 8'h00);
  endtask
  task automatic t_tx();
    wr(10'h043, 8'h01);
    wr(10'h042, 8'h18);
    rd_chk(10'h042, 8'h18);
    repeat (3) @(posedge core_clk);
    chk({7'h00, ck_oe_n}, 8'h01);
    @(posedge core_clk) go <= 1'b1;
    wait_slot();
    chk({1'b0, s_num}, 8'h00);
    chk(s_data, 8'hA5);
    chk(s_sig, 8'h3C);
    wait_slot();
    chk({1'b0, s_num}, 8'h01);
    chk(s_data, 8'hA5);
  endtask

  task automatic t_master();
    logic b;
    repeat (200) begin
      @(posedge core_clk);
      #1;
      if (fp_out === 1'b1) break;
    end
    chk({6'h00, fp_oe_n, fp_out}, 8'h01);
    b = ck_out;
    repeat (TX_HALF_CYCLES) @(posedge core_clk);
    #1;
    chk({7'h00, ck_out}, {7'h00, ~b});
    repeat (TX_HALF_CYCLES) @(posedge core_clk);
    #1;
    chk({6'h00, ck_out, fp_out}, {6'h00, b, 1'b0});
  endtask
  task automatic t_offset();
    wr(10'h044, 8'h01);
    @(posedge core_clk) go <= 1'b0;
    repeat (10) @(posedge core_clk);
    go <= 1'b1;
    wait_slot();
    chk({1'b0, s_num}, 8'h1F);
    chk(s_sig, 8'h3C);
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #900us;
    fail_count++;
    end_sim();
  end
  initial begin
    {rst, reg_wr, reg_rd, bipolar_violation, excess_zero, loss_of_signal, master_clock} = 7'h40;
    {go, reg_addr, reg_wdata, line_irq_flags} = '0;
    func0_irq_flags = '0;
    func1_irq_flags = '0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    t_reset();
    t_master();
    t_flags();
    t_count();
    t_ref();
    t_sum();
    t_tx();
    t_offset();
    end_sim();
  end
endmodule
